// ### logic/codec_mixer_pkg.sv
// Purpose: shared constants for the codec mixer register bank
// Assumes: register indices are the 7-bit link indices (even numbers)
// Notes: reset values and field positions live here; write masks are in the bank
package codec_mixer_pkg;
   localparam int IDX_W = 7;
   localparam int DATA_W = 16;
   localparam int NUM_WORDS = 64;
   // register indices
   localparam logic [6:0] IDX_RESET_CAP = 7'h00;
   localparam logic [6:0] IDX_MASTER = 7'h02;
   localparam logic [6:0] IDX_HEADPHONE = 7'h04;
   localparam logic [6:0] IDX_MONO = 7'h06;
   localparam logic [6:0] IDX_BEEP = 7'h0A;
   localparam logic [6:0] IDX_PHONE = 7'h0C;
   localparam logic [6:0] IDX_MIC = 7'h0E;
   localparam logic [6:0] IDX_LINE = 7'h10;
   localparam logic [6:0] IDX_PCM_OUT = 7'h18;
   localparam logic [6:0] IDX_REC_SEL = 7'h1A;
   localparam logic [6:0] IDX_REC_GAIN = 7'h1C;
   localparam logic [6:0] IDX_GEN_PURPOSE = 7'h20;
   localparam logic [6:0] IDX_POWERDOWN = 7'h26;
   localparam logic [6:0] IDX_EXT_AUDIO_CAP = 7'h28;
   localparam logic [6:0] IDX_EXT_AUDIO_CTL = 7'h2A;
   localparam logic [6:0] IDX_PLAY_RATE = 7'h2C;
   localparam logic [6:0] IDX_CAPT_RATE = 7'h32;
   localparam logic [6:0] IDX_DIG_OUT = 7'h3A;
   localparam logic [6:0] IDX_EXT_MODEM_CAP = 7'h3C;
   localparam logic [6:0] IDX_EXT_MODEM_CTL = 7'h3E;
   localparam logic [6:0] IDX_PIN_DIR = 7'h4C;
   localparam logic [6:0] IDX_PIN_POL = 7'h4E;
   localparam logic [6:0] IDX_PIN_STICKY = 7'h50;
   localparam logic [6:0] IDX_PIN_WAKE = 7'h52;
   localparam logic [6:0] IDX_PIN_LEVEL = 7'h54;
   localparam logic [6:0] IDX_LINK_MODE = 7'h5E;
   localparam logic [6:0] IDX_MISC_CLOCK = 7'h60;
   localparam logic [6:0] IDX_SERIAL_OUT = 7'h6A;
   localparam logic [6:0] IDX_FW_ENABLE = 7'h70;
   localparam logic [6:0] IDX_FW_WAKE = 7'h72;
   localparam logic [6:0] IDX_FW_STATUS = 7'h7A;
   localparam logic [6:0] IDX_MAKER_FIRST = 7'h7C;
   localparam logic [6:0] IDX_MAKER_SECOND = 7'h7E;
   // register-reset ranges
   localparam logic [6:0] STD_RESET_LAST = 7'h3A;
   localparam logic [6:0] VND_RESET_FIRST = 7'h5A;
   localparam logic [6:0] VND_RESET_LAST = 7'h7A;
   // reset values
   localparam logic [15:0] CAP_WORD = 16'h0190;
   localparam int HP_FLAG_BIT = 4;
   localparam logic [15:0] RST_OUT_VOL = 16'h8000;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_MONO_GAIN = 16'h8008;
   localparam logic [15:0] RST_STEREO_GAIN = 16'h8808;
   localparam logic [15:0] RST_POWERDOWN = 16'h000F;
   localparam logic [15:0] RST_EXT_AUDIO_CAP = 16'h0605;
   localparam logic [15:0] RST_EXT_AUDIO_CTL = 16'h0410;
   localparam logic [15:0] RST_RATE = 16'hBB80;
   localparam logic [15:0] RST_DIG_OUT = 16'h2000;
   localparam logic [15:0] RST_EXT_MODEM_CTL = 16'h0100;
   localparam logic [15:0] RST_PIN_DIR = 16'h001F;
   localparam logic [15:0] RST_PIN_POL = 16'hFFFF;
   localparam logic [15:0] RST_MISC_CLOCK = 16'h0003;
   // field positions
   localparam int MUTE_BIT = 15;
   localparam int LEFT_LSB = 8;
   localparam int SAT_BIT = 5;
   localparam logic [5:0] ATTEN_MAX = 6'h1F;
   localparam int MIC_BOOST_HIGH_BIT = 6;
   localparam int MIC_BOOST_LOW_BIT = 7;
   localparam int MIC_SELECT_BIT = 8;
   localparam int NUM_STEREO = 5;
endpackage

// ### logic/codec_mixer_register_bank.sv
// Purpose: mixer and control register bank of an audio codec
// Assumes: link framer decodes slots and hands over one access per frame
// Notes: reads answer at the next frame_start, snapshot taken at request
`timescale 1ns/1ps
`default_nettype none
module codec_mixer_register_bank
   import codec_mixer_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE_FIRST = 16'h1234, // arbitrary value
   parameter logic [15:0] MAKER_CODE_SECOND = 16'h5678 // arbitrary value
)(
   input wire logic mclk,
   input wire logic reset,
   input wire logic link_ready,
   input wire logic frame_start,
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic [6:0] acc_index,
   input wire logic [15:0] acc_wdata,
   input wire logic headphone_config_pin,
   input wire logic cold_reset_n,
   output logic rsp_valid,
   output logic [6:0] rsp_index,
   output logic [15:0] rsp_data,
   output logic master_mute,
   output logic [5:0] master_left_atten,
   output logic [5:0] master_right_atten,
   output logic hp_mute,
   output logic [5:0] hp_left_atten,
   output logic [5:0] hp_right_atten,
   output logic mono_mute,
   output logic [5:0] mono_out_atten,
   output logic beep_mute,
   output logic [3:0] beep_atten,
   output logic phone_mute,
   output logic [4:0] phone_gain,
   output logic first_mic_mute,
   output logic second_mic_mute,
   output logic [4:0] mic_gain,
   output logic mic_boost_high,
   output logic mic_boost_low,
   output logic [4:0] stereo_mute,
   output logic [4:0][4:0] stereo_left_gain,
   output logic [4:0][4:0] stereo_right_gain,
   output logic [2:0] left_record_source,
   output logic [2:0] right_record_source,
   output logic [7:0] left_record_sel,
   output logic [7:0] right_record_sel
);

   // writable bits of each index; everything else is fixed or read-only
   function automatic logic [15:0] write_mask(input logic [6:0] idx);
      logic [15:0] m;
      m = 16'h0000;
      if (idx == IDX_MASTER || idx == IDX_HEADPHONE) m = 16'hBF3F;
      else if (idx == IDX_MONO) m = 16'h803F;
      else if (idx == IDX_BEEP) m = 16'h801E;
      else if (idx == IDX_PHONE) m = 16'h801F;
      else if (idx == IDX_MIC) m = 16'h805F;
      else if (idx >= IDX_LINE && idx <= IDX_PCM_OUT) m = 16'h9F1F;
      else if (idx == IDX_REC_SEL) m = 16'h0707;
      else if (idx == IDX_REC_GAIN) m = 16'h8F0F;
      else if (idx == IDX_GEN_PURPOSE) m = 16'h0380;
      else if (idx == IDX_POWERDOWN) m = 16'hFF00;
      else if (idx == IDX_EXT_AUDIO_CAP) m = 16'h0030;
      else if (idx == IDX_EXT_AUDIO_CTL) m = 16'h0035;
      else if (idx == IDX_PLAY_RATE || idx == IDX_CAPT_RATE) m = 16'hFFFF;
      else if (idx == IDX_DIG_OUT) m = 16'hFFFF;
      else if (idx == IDX_EXT_MODEM_CTL) m = 16'h0100;
      else if (idx == IDX_PIN_DIR || idx == IDX_PIN_POL) m = 16'h001F;
      else if (idx == IDX_PIN_STICKY || idx == IDX_PIN_WAKE) m = 16'h001F;
      else if (idx == IDX_PIN_LEVEL) m = 16'h001F;
      else if (idx == IDX_LINK_MODE) m = 16'h0B30;
      else if (idx == IDX_MISC_CLOCK) m = 16'h10C9;
      else if (idx == IDX_SERIAL_OUT) m = 16'h800F;
      else if (idx == IDX_FW_ENABLE || idx == IDX_FW_WAKE) m = 16'hFFFF;
      else if (idx == IDX_FW_STATUS) m = 16'hFFFF;
      return m;
   endfunction

   // default contents; unmapped words stay zero forever
   function automatic logic [15:0] reset_value(input logic [6:0] idx);
      logic [15:0] v;
      v = RST_ZERO;
      if (idx == IDX_MASTER || idx == IDX_HEADPHONE) v = RST_OUT_VOL;
      else if (idx == IDX_MONO || idx == IDX_REC_GAIN) v = RST_OUT_VOL;
      else if (idx == IDX_PHONE || idx == IDX_MIC) v = RST_MONO_GAIN;
      else if (idx >= IDX_LINE && idx <= IDX_PCM_OUT) v = RST_STEREO_GAIN;
      else if (idx == IDX_POWERDOWN) v = RST_POWERDOWN;
      else if (idx == IDX_EXT_AUDIO_CAP) v = RST_EXT_AUDIO_CAP;
      else if (idx == IDX_EXT_AUDIO_CTL) v = RST_EXT_AUDIO_CTL;
      else if (idx == IDX_PLAY_RATE || idx == IDX_CAPT_RATE) v = RST_RATE;
      else if (idx == IDX_DIG_OUT) v = RST_DIG_OUT;
      else if (idx == IDX_EXT_MODEM_CTL) v = RST_EXT_MODEM_CTL;
      else if (idx == IDX_PIN_DIR) v = RST_PIN_DIR;
      else if (idx == IDX_PIN_POL) v = RST_PIN_POL;
      else if (idx == IDX_MISC_CLOCK) v = RST_MISC_CLOCK;
      return v;
   endfunction

   // saturate a 6-bit attenuation: bit 5 forces full scale
   function automatic logic [5:0] sat_atten(input logic [5:0] a);
      return a[SAT_BIT] ? ATTEN_MAX : a;
   endfunction

   // record selector code to one-hot source
   function automatic logic [7:0] source_onehot(input logic [2:0] code);
      return 8'h01 << code;
   endfunction

   logic [15:0] regs [0:NUM_WORDS-1];
   logic [15:0] next_regs [0:NUM_WORDS-1];
   logic hp_meta, hp_sync, cold_meta, cold_sync;
   logic pend, next_pend;
   logic [6:0] pend_index, next_pend_index;
   logic [15:0] pend_data, next_pend_data;
   logic next_rsp_valid;
   logic [6:0] next_rsp_index;
   logic [15:0] next_rsp_data;
   logic accept, wr_hit, rd_hit;
   logic [15:0] cap_word, read_word;
   logic [15:0] out_reg, hp_reg;

   // pins pass two flops before anything reads them
   always_ff @(posedge mclk) begin
      if (reset) begin
         hp_meta <= 1'b1;
         hp_sync <= 1'b1;
         cold_meta <= 1'b1;
         cold_sync <= 1'b1;
      end else begin
         hp_meta <= headphone_config_pin;
         hp_sync <= hp_meta;
         cold_meta <= cold_reset_n;
         cold_sync <= cold_meta;
      end
   end

   // accesses are dropped outright while the link is not ready
   assign accept = acc_valid & link_ready;
   assign wr_hit = accept & acc_write;
   assign rd_hit = accept & ~acc_write;

   // capability word with the live headphone flag
   always_comb begin
      cap_word = CAP_WORD;
      cap_word[HP_FLAG_BIT] = hp_sync;
   end

   // read mux; pin low turns index 04h into a zero read-only word
   always_comb begin
      read_word = regs[acc_index[6:1]];
      if (acc_index == IDX_RESET_CAP) read_word = cap_word;
      else if (acc_index == IDX_HEADPHONE && !hp_sync) read_word = 16'h0000;
      else if (acc_index == IDX_MAKER_FIRST) read_word = MAKER_CODE_FIRST;
      else if (acc_index == IDX_MAKER_SECOND) read_word = MAKER_CODE_SECOND;
      else if (acc_index[0]) read_word = 16'h0000;
   end

   // register file next state: masked writes, saturation, register reset
   always_comb begin
      logic [15:0] w;
      logic [6:0] ix;
      w = 16'h0000;
      ix = 7'h00;
      for (int i = 0; i < NUM_WORDS; i++) begin
         next_regs[i] = regs[i];
      end
      if (wr_hit && acc_index == IDX_RESET_CAP) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            ix = 7'(i * 2);
            if (ix <= STD_RESET_LAST ||
                (ix >= VND_RESET_FIRST && ix <= VND_RESET_LAST)) begin
               next_regs[i] = reset_value(ix);
            end
         end
      end else if (wr_hit && !acc_index[0] &&
                   !(acc_index == IDX_HEADPHONE && !hp_sync)) begin
         w = acc_wdata;
         if (acc_index == IDX_MASTER || acc_index == IDX_HEADPHONE ||
             acc_index == IDX_MONO) begin
            w[13:8] = sat_atten(acc_wdata[13:8]);
            w[5:0] = sat_atten(acc_wdata[5:0]);
         end
         // fixed bits keep their value, data to them is discarded
         next_regs[acc_index[6:1]] = (regs[acc_index[6:1]] &
            ~write_mask(acc_index)) | (w & write_mask(acc_index));
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            regs[i] <= reset_value(7'(i * 2));
         end
      end else begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            regs[i] <= next_regs[i];
         end
      end
   end

   // read answer: snapshot now, present at the next frame start
   always_comb begin
      next_pend = pend;
      next_pend_index = pend_index;
      next_pend_data = pend_data;
      next_rsp_valid = 1'b0;
      next_rsp_index = rsp_index;
      next_rsp_data = rsp_data;
      if (frame_start && pend) begin
         next_rsp_valid = 1'b1;
         next_rsp_index = pend_index;
         next_rsp_data = pend_data;
         next_pend = 1'b0;
      end
      // a new read in the same cycle overrides the clear
      if (rd_hit) begin
         next_pend = 1'b1;
         next_pend_index = acc_index;
         next_pend_data = read_word;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         pend <= 1'b0;
         pend_index <= 7'h00;
         pend_data <= 16'h0000;
         rsp_valid <= 1'b0;
         rsp_index <= 7'h00;
         rsp_data <= 16'h0000;
      end else begin
         pend <= next_pend;
         pend_index <= next_pend_index;
         pend_data <= next_pend_data;
         rsp_valid <= next_rsp_valid;
         rsp_index <= next_rsp_index;
         rsp_data <= next_rsp_data;
      end
   end

   // output routing depends on the headphone pin
   assign out_reg = regs[IDX_MASTER[6:1]];
   assign hp_reg = hp_sync ? regs[IDX_HEADPHONE[6:1]] : out_reg;

   // registered control outputs for the analog paths
   always_ff @(posedge mclk) begin
      if (reset) begin
         master_mute <= 1'b1;
         master_left_atten <= 6'h00;
         master_right_atten <= 6'h00;
         hp_mute <= 1'b1;
         hp_left_atten <= 6'h00;
         hp_right_atten <= 6'h00;
         beep_mute <= 1'b0;
         beep_atten <= 4'h0;
         first_mic_mute <= 1'b1;
         second_mic_mute <= 1'b0;
      end else begin
         // with the pin low the master path is held muted
         master_mute <= hp_sync ? out_reg[MUTE_BIT] : 1'b1;
         master_left_atten <= hp_sync ? out_reg[13:8] : 6'h00;
         master_right_atten <= hp_sync ? out_reg[5:0] : 6'h00;
         hp_mute <= hp_reg[MUTE_BIT];
         hp_left_atten <= hp_reg[13:8];
         hp_right_atten <= hp_reg[5:0];
         // cold reset holds beep at its neutral setting
         beep_mute <= cold_sync & regs[IDX_BEEP[6:1]][MUTE_BIT];
         beep_atten <= cold_sync ? regs[IDX_BEEP[6:1]][4:1] : 4'h0;
         first_mic_mute <= regs[IDX_MIC[6:1]][MUTE_BIT] &
            ~regs[IDX_GEN_PURPOSE[6:1]][MIC_SELECT_BIT];
         second_mic_mute <= regs[IDX_MIC[6:1]][MUTE_BIT] &
            regs[IDX_GEN_PURPOSE[6:1]][MIC_SELECT_BIT];
      end
   end

   // direct field views of the flops
   assign mono_mute = regs[IDX_MONO[6:1]][MUTE_BIT];
   assign mono_out_atten = regs[IDX_MONO[6:1]][5:0];
   assign phone_mute = regs[IDX_PHONE[6:1]][MUTE_BIT];
   assign phone_gain = regs[IDX_PHONE[6:1]][4:0];
   assign mic_gain = regs[IDX_MIC[6:1]][4:0];
   assign mic_boost_high = regs[IDX_MIC[6:1]][MIC_BOOST_HIGH_BIT];
   assign mic_boost_low = regs[IDX_MISC_CLOCK[6:1]][MIC_BOOST_LOW_BIT];
   assign left_record_source = regs[IDX_REC_SEL[6:1]][10:8];
   assign right_record_source = regs[IDX_REC_SEL[6:1]][2:0];
   assign left_record_sel = source_onehot(left_record_source);
   assign right_record_sel = source_onehot(right_record_source);

   // one stereo gain word per source: line, CD, video, aux, PCM
   for (genvar s = 0; s < NUM_STEREO; s++) begin : g_stereo
      assign stereo_mute[s] = regs[(IDX_LINE >> 1) + s][MUTE_BIT];
      assign stereo_left_gain[s] = regs[(IDX_LINE >> 1) + s][12:8];
      assign stereo_right_gain[s] = regs[(IDX_LINE >> 1) + s][4:0];
   end

   // checks on the behaviour of the bank
   AST_CAP_WORD: assert property (@(posedge mclk) disable iff (reset)
      rsp_valid && rsp_index == IDX_RESET_CAP |->
         {rsp_data[15:5], rsp_data[3:0]} == {CAP_WORD[15:5], CAP_WORD[3:0]})
      else $error("capability word wrong");
   AST_HP_FLAG: assert property (@(posedge mclk) disable iff (reset)
      rd_hit && acc_index == IDX_RESET_CAP ##1 pend |->
         pend_data[HP_FLAG_BIT] == $past(hp_sync))
      else $error("headphone flag does not follow pin");
   AST_REG_RESET: assert property (@(posedge mclk) disable iff (reset)
      wr_hit && acc_index == IDX_RESET_CAP |=> ##1
         mono_mute && mono_out_atten == 6'h00 && stereo_mute == 5'h1F)
      else $error("register reset missed");
   AST_SATURATE: assert property (@(posedge mclk) disable iff (reset)
      wr_hit && acc_index == IDX_MONO && acc_wdata[SAT_BIT] |=>
         mono_out_atten == ATTEN_MAX)
      else $error("attenuation not saturated");
   AST_HP_RO: assert property (@(posedge mclk) disable iff (reset)
      rd_hit && acc_index == IDX_HEADPHONE && !hp_sync |=> pend_data == 16'h0)
      else $error("headphone word not zero with pin low");
   AST_ODD_ZERO: assert property (@(posedge mclk) disable iff (reset)
      rd_hit && acc_index[0] |=> pend_data == 16'h0000)
      else $error("odd index read not zero");
   AST_BEEP_COLD: assert property (@(posedge mclk) disable iff (reset)
      !cold_sync |=> !beep_mute && beep_atten == 4'h0)
      else $error("beep setting active during cold reset");
   AST_NOT_READY: assert property (@(posedge mclk) disable iff (reset)
      acc_valid && !link_ready && !pend |=> !pend)
      else $error("access taken while link not ready");
   AST_RSP_FRAME: assert property (@(posedge mclk) disable iff (reset)
      rsp_valid |-> $past(frame_start) && $past(pend))
      else $error("answer outside frame start");
   AST_MIC_SEL: assert property (@(posedge mclk) disable iff (reset)
      {first_mic_mute, second_mic_mute} ==
         (!$past(regs[IDX_MIC[6:1]][MUTE_BIT]) ? 2'b00 :
          $past(regs[IDX_GEN_PURPOSE[6:1]][MIC_SELECT_BIT]) ? 2'b01 : 2'b10))
      else $error("microphone mute on the wrong input");
   AST_REC_ONEHOT: assert property (@(posedge mclk) disable iff (reset)
      $onehot(left_record_sel) && $onehot(right_record_sel) &&
      left_record_sel[0] == (left_record_source == 3'b000) &&
      right_record_sel[7] == (right_record_source == 3'b111))
      else $error("record select not one-hot");
   COV_READ: cover property (@(posedge mclk) disable iff (reset)
      rd_hit ##[1:600] rsp_valid);
   COV_REG_RESET: cover property (@(posedge mclk) disable iff (reset)
      wr_hit && acc_index == IDX_RESET_CAP);
   COV_PIN_LOW: cover property (@(posedge mclk) disable iff (reset)
      wr_hit && acc_index == IDX_HEADPHONE && !hp_sync);
   COV_COLD_BEEP: cover property (@(posedge mclk) disable iff (reset)
      !cold_sync && regs[IDX_BEEP[6:1]][MUTE_BIT]);
   COV_MIC_SECOND: cover property (@(posedge mclk) disable iff (reset)
      second_mic_mute);

endmodule
`default_nettype wire

// ### verif/link_master_model.sv
// Purpose: controller-side model handing decoded link accesses to the bank
// Assumes: a frame every 8 mclk cycles; requests move 1 ns after the edge
// Notes: released write data shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module link_master_model(
   input wire logic mclk,
   input wire logic link_ready,
   output logic frame_start,
   output logic acc_valid,
   output logic acc_write,
   output logic [6:0] acc_index,
   output logic [15:0] acc_wdata,
   input wire logic rsp_valid,
   input wire logic [6:0] rsp_index,
   input wire logic [15:0] rsp_data
);
   logic [2:0] fcnt = 3'h0;
   initial begin
      frame_start = 1'b0;
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_index = 7'h00;
      acc_wdata = 16'h0000;
   end
   // free-running frame marker, one pulse per frame
   always @(posedge mclk) begin
      fcnt <= fcnt + 3'h1;
      frame_start <= (fcnt == 3'h7);
   end
   // one access held for exactly one sampling edge
   task issue(input logic wr, input logic [6:0] idx, input logic [15:0] d);
      @(posedge mclk);
      #1;
      acc_valid = 1'b1;
      acc_write = wr;
      acc_index = idx;
      acc_wdata = d;
      @(posedge mclk);
      #1;
      acc_valid = 1'b0;
      acc_wdata = ~d;
   endtask
   // read answer lands a frame later; the wait is bounded
   task fetch(input logic [6:0] idx, output logic [6:0] ri,
      output logic [15:0] rd, output bit ok);
      issue(1'b0, idx, acc_wdata);
      for (int n = 0; n < 40 && rsp_valid !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      ok = (rsp_valid === 1'b1);
      ri = rsp_index;
      rd = rsp_data;
   endtask
endmodule
`default_nettype wire

// ### verif/test_codec_mixer_register_bank.sv
// Purpose: self-checking bench for the codec mixer register bank
// Assumes: registered outputs settle within 2 edges after a write
// Notes: headphone pin and cold reset are driven from here
`timescale 1ns/1ps
`default_nettype none
module test_codec_mixer_register_bank;
   import codec_mixer_pkg::*;
   logic mclk, reset, link_ready, hp_pin, cold_n, frame_start, acc_valid;
   logic acc_write, rsp_valid, master_mute, hp_mute, beep_mute;
   logic first_mic_mute, second_mic_mute, mic_boost_high;
   logic mono_mute, phone_mute, mic_boost_low;
   logic [5:0] master_right_atten, hp_right_atten;
   logic [4:0] phone_gain, mic_gain, stereo_mute;
   logic [2:0] left_record_source, right_record_source;
   logic [6:0] acc_index, rsp_index;
   logic [15:0] acc_wdata, rsp_data;
   logic [5:0] master_left_atten, hp_left_atten, mono_out_atten;
   logic [3:0] beep_atten;
   logic [4:0][4:0] stereo_left_gain, stereo_right_gain;
   logic [7:0] left_record_sel, right_record_sel;
   int miscompares, checked;
   codec_mixer_register_bank codec_mixer_register_bank_inst(
      .mclk(mclk), .reset(reset), .link_ready(link_ready),
      .frame_start(frame_start), .acc_valid(acc_valid),
      .acc_write(acc_write), .acc_index(acc_index), .acc_wdata(acc_wdata),
      .headphone_config_pin(hp_pin), .cold_reset_n(cold_n),
      .rsp_valid(rsp_valid), .rsp_index(rsp_index), .rsp_data(rsp_data),
      .master_mute(master_mute), .master_left_atten(master_left_atten),
      .master_right_atten(master_right_atten), .hp_mute(hp_mute),
      .hp_left_atten(hp_left_atten), .hp_right_atten(hp_right_atten),
      .mono_mute(mono_mute),
      .mono_out_atten(mono_out_atten), .beep_mute(beep_mute),
      .beep_atten(beep_atten), .phone_mute(phone_mute),
      .phone_gain(phone_gain),
      .first_mic_mute(first_mic_mute), .second_mic_mute(second_mic_mute),
      .mic_gain(mic_gain), .mic_boost_high(mic_boost_high),
      .mic_boost_low(mic_boost_low),
      .stereo_mute(stereo_mute), .stereo_left_gain(stereo_left_gain),
      .stereo_right_gain(stereo_right_gain),
      .left_record_source(left_record_source),
      .right_record_source(right_record_source),
      .left_record_sel(left_record_sel),
      .right_record_sel(right_record_sel));
   link_master_model link_master_model_inst(
      .mclk(mclk), .link_ready(link_ready), .frame_start(frame_start),
      .acc_valid(acc_valid), .acc_write(acc_write), .acc_index(acc_index),
      .acc_wdata(acc_wdata), .rsp_valid(rsp_valid),
      .rsp_index(rsp_index), .rsp_data(rsp_data));
   always #2 mclk = ~mclk;
   // case equality so an unknown never passes
   task check(input string what, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // two extra edges let the registered outputs follow the write
   task wr(input logic [6:0] idx, input logic [15:0] d);
      link_master_model_inst.issue(1'b1, idx, d);
      cyc(2);
   endtask
   task rd(input logic [6:0] idx, input logic [15:0] exp);
      logic [6:0] ri;
      logic [15:0] d;
      bit ok;
      link_master_model_inst.fetch(idx, ri, d, ok);
      if (!ok) begin
         miscompares++;
         end_of_test;
      end
      check("echo", {9'h0, ri}, {9'h0, idx});
      check("read", d, exp);
   endtask
   // 08h is outside the map and must read zero
   task t_defaults;
      logic [6:0] ix [12] = '{7'h00, 7'h02, 7'h04, 7'h06, 7'h0A, 7'h0C,
         7'h0E, 7'h10, 7'h18, 7'h1A, 7'h1C, 7'h08};
      logic [15:0] ev [12] = '{16'h0190, 16'h8000, 16'h8000, 16'h8000,
         16'h0000, 16'h8008, 16'h8008, 16'h8808, 16'h8808, 16'h0000,
         16'h8000, 16'h0000};
      foreach (ix[i]) rd(ix[i], ev[i]);
      rd(7'h09, 16'h0000);
   endtask
   task t_atten;
      wr(7'h02, 16'hFFFF);
      rd(7'h02, 16'h9F1F);
      check("m_att", {9'h0, master_mute, master_left_atten}, 16'h005F);
      wr(7'h02, 16'h0125);
      rd(7'h02, 16'h011F);
      check("m_att", {9'h0, master_mute, master_left_atten}, 16'h0001);
      check("m_r", {10'h0, master_right_atten}, 16'h001F);
      wr(7'h04, 16'h0203);
      check("hp", {9'h0, hp_mute, hp_left_atten}, 16'h0002);
      check("hp_r", {10'h0, hp_right_atten}, 16'h0003);
      wr(7'h06, 16'h0020);
      rd(7'h06, 16'h001F);
      check("mono", {10'h0, mono_out_atten}, 16'h001F);
      check("mono_m", {15'h0, mono_mute}, 16'h0000);
   endtask
   // beep setting must be masked while the cold reset pin is low
   task t_beep;
      wr(7'h0A, 16'hFFFF);
      rd(7'h0A, 16'h801E);
      check("beep", {11'h0, beep_mute, beep_atten}, 16'h001F);
      cold_n = 1'b0;
      cyc(4);
      check("beep_cr", {11'h0, beep_mute, beep_atten}, 16'h0000);
      cold_n = 1'b1;
      cyc(4);
   endtask
   task t_stereo;
      wr(7'h12, 16'h0A03);
      rd(7'h12, 16'h0A03);
      check("cd_l", {11'h0, stereo_left_gain[1]}, 16'h000A);
      check("cd_r", {11'h0, stereo_right_gain[1]}, 16'h0003);
      check("line_l", {11'h0, stereo_left_gain[0]}, 16'h0008);
      check("st_mute", {11'h0, stereo_mute}, 16'h001D);
   endtask
   task t_rec;
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         wr(7'h1A, {5'h0, c, 5'h0, ~c});
         rd(7'h1A, {5'h0, c, 5'h0, ~c});
         check("rec_l", {8'h0, left_record_sel}, 16'h0001 << i);
         check("rec_r", {8'h0, right_record_sel}, 16'h0080 >> i);
         check("rec_src", {5'h0, left_record_source, 5'h0,
            right_record_source}, {5'h0, c, 5'h0, ~c});
      end
   endtask
   task t_mic;
      wr(7'h20, 16'h0100);
      wr(7'h0E, 16'h8047);
      check("mic", {13'h0, first_mic_mute, second_mic_mute,
         mic_boost_high}, 16'h0003);
      wr(7'h20, 16'h0000);
      check("mic", {13'h0, first_mic_mute, second_mic_mute,
         mic_boost_high}, 16'h0005);
      check("mic_gain", {11'h0, mic_gain}, 16'h0007);
      wr(7'h60, 16'h0080);
      check("boost_lo", {15'h0, mic_boost_low}, 16'h0001);
      wr(7'h0C, 16'h0015);
      check("phone", {10'h0, phone_mute, phone_gain}, 16'h0015);
   endtask
   // a write with the link not ready must leave 02h alone
   task t_ready;
      link_ready = 1'b0;
      wr(7'h02, 16'h0000);
      link_ready = 1'b1;
      rd(7'h02, 16'h011F);
   endtask
   task t_reg_reset;
      wr(7'h00, 16'h1234);
      rd(7'h00, 16'h0190);
      rd(7'h02, 16'h8000);
      rd(7'h12, 16'h8808);
      rd(7'h0E, 16'h8008);
   endtask
   task t_hp_low;
      hp_pin = 1'b0;
      cyc(4);
      rd(7'h00, 16'h0180);
      wr(7'h04, 16'h1234);
      rd(7'h04, 16'h0000);
      wr(7'h02, 16'h0305);
      check("hp", {9'h0, master_mute, hp_left_atten}, 16'h0043);
      check("hp_r", {9'h0, hp_mute, hp_right_atten}, 16'h0005);
      check("m_r", {10'h0, master_right_atten}, 16'h0000);
   endtask
   initial begin
      mclk = 1'b0;
      reset = 1'b1;
      link_ready = 1'b0;
      hp_pin = 1'b1;
      cold_n = 1'b1;
      miscompares = 0;
      checked = 0;
      cyc(8);
      reset = 1'b0;
      link_ready = 1'b1;
      cyc(3);
      t_defaults();
      t_atten();
      t_beep();
      t_stereo();
      t_rec();
      t_mic();
      t_ready();
      t_reg_reset();
      t_hp_low();
      end_of_test();
   end
endmodule
`default_nettype wire
